// ===== inc/gdh_pkg.sv
package gdh_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_SLAVE    = 8'h04;
  localparam logic [7:0]  OFF_RATIO    = 8'h08;
  localparam logic [7:0]  OFF_STATUS   = 8'h0c;
  localparam logic [7:0]  OFF_ERRCODE  = 8'h10;
  localparam logic [7:0]  OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0]  OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0]  OFF_VEL      = 8'h1c;

  // control register fields
  localparam int          CTRL_START   = 0;   // level, rising edge starts a disengage
  localparam int          CTRL_ENGAGE  = 1;   // write one while not busy: couple slave to master

  // ratio register fields
  localparam int          RATIO_NUM_LSB = 0;
  localparam int          RATIO_DEN_LSB = 16;

  // status register fields
  localparam int          ST_DONE      = 0;
  localparam int          ST_BUSY      = 1;
  localparam int          ST_ABORT     = 2;
  localparam int          ST_ERR       = 3;
  localparam int          ST_LOCK      = 4;
  localparam int          ST_CONT      = 5;
  localparam int          ST_HALT      = 6;

  // interrupt status and mask fields
  localparam int          IRQ_W        = 3;
  localparam int          IRQ_DONE     = 0;
  localparam int          IRQ_ABORT    = 1;
  localparam int          IRQ_ERR      = 2;

  // reset values
  localparam logic [15:0] RST_SLAVE    = 16'h0000;
  localparam logic [15:0] RST_NUM      = 16'h0001;
  localparam logic [15:0] RST_DEN      = 16'h0001;
  localparam logic [2:0]  RST_MASK     = 3'h0;

  // legal slave axis numbers
  localparam logic [15:0] AXIS_MIN     = 16'h0001;
  localparam logic [15:0] AXIS_MAX     = 16'h0020;

  // error codes, values are arbitrary
  localparam logic [31:0] ERR_NONE     = 32'h0000_0000;
  localparam logic [31:0] ERR_AXIS     = 32'h0000_0001;
  localparam logic [31:0] ERR_NOLOCK   = 32'h0000_0002;
  localparam logic [31:0] ERR_ESTOP    = 32'h0000_0003;

  // scan period timing
  localparam int          CLK_NS       = 10;
  localparam int          SCAN_NS      = 1000;
  localparam int          SCAN_CYC     = SCAN_NS / CLK_NS;
  localparam logic [6:0]  SCAN_LAST    = 7'(SCAN_CYC - 1);

  // command sequencer states
  typedef enum logic [1:0] {
    GDH_IDLE = 2'b01,
    GDH_CUT  = 2'b10
  } gdh_state_t;

endpackage

// ===== src/gdh_sync.sv
`timescale 1ns/1ps
// three stage synchroniser, output moves once stages two and three agree
module gdh_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout
);

  typedef struct packed {
    logic s1;   // metastable stage, read only by s2
    logic s2;
    logic s3;
    logic q;    // filtered level
  } gdh_sync_t;

  gdh_sync_t s_r;
  gdh_sync_t s_nxt;

  // next state: shift and accept agreed value
  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = din;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    if (s_r.s2 == s_r.s3) begin
      s_nxt.q = s_r.s3;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.q;

endmodule

// ===== src/gdh_ratio.sv
`timescale 1ns/1ps
// gear follower: slave velocity is master velocity times num over den
module gdh_ratio (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic signed [31:0] master_vel,
  input  wire logic signed [15:0] num,
  input  wire logic signed [15:0] den,
  output logic signed [31:0]      follow_vel
);

  typedef struct packed {
    logic signed [31:0] vel;   // registered follower velocity
  } gdh_ratio_t;

  gdh_ratio_t s_r;
  gdh_ratio_t s_nxt;

  // next velocity; a negative ratio turns the direction round
  always_comb begin
    logic signed [47:0] prod;
    logic signed [47:0] quo;
    prod  = 48'(master_vel) * 48'(num);
    quo   = '0;
    s_nxt = s_r;
    if (den != 16'sh0000) begin   // zero divisor keeps the slave still
      quo = prod / 48'(den);
    end
    s_nxt.vel = quo[31:0];
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign follow_vel = s_r.vel;

endmodule

// ===== src/gdh_gear_disengage_block.sv
`timescale 1ns/1ps
// Function
// - disengage begins only on start rising edge
// - axis number 1..max, sampled at start rise
// - slave stops following, keeps cut velocity
// - afterwards slave in continuous motion, free
// - done rises when disconnection has completed
// - done clears on start fall, else one scan
// - busy on start rise, off at result
// - aborted on aborting-mode command or stop
// - aborted clears on start fall, else one scan
// - bad input raises error with code; fall clears
// - error-stop at start or during a cut halts the axis
// - engaged slave follows master by signed ratio
module gdh_gear_disengage_block (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] master_vel,
  input  wire logic        abort_buffer_mode,
  input  wire logic        axis_stop_command,
  input  wire logic        axis_errstop,
  output logic             done,
  output logic             busy,
  output logic             aborted_flag,
  output logic             error,
  output logic [31:0]      error_code_output,
  output logic [31:0]      slave_vel,
  output logic             gear_locked_flag,
  output logic             continuous_motion_state,
  output logic             halt,
  output logic             irq
);

  typedef struct packed {
    logic                   start;       // start level from software
    logic [15:0]            slave_sel;   // axis number as written
    logic [15:0]            num;         // ratio numerator
    logic [15:0]            den;         // ratio denominator
    logic [2:0]             mask;        // interrupt mask
    logic [2:0]             irq_stat;    // sticky events
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic [6:0]             scan_cnt;    // scan period divider
    logic                   tick;        // one cycle per scan
    logic                   start_prev;  // start seen at last scan
    logic [15:0]            axis;        // latched slave number
    gdh_pkg::gdh_state_t    st;
    logic                   done;
    logic                   busy;
    logic                   aborted;
    logic                   error;
    logic [31:0]            errcode;
    logic                   lock;        // gear coupled
    logic                   cont;        // continuous motion
    logic                   halt;        // axis halted by error
    logic [31:0]            vel;         // commanded slave velocity
    logic                   abort_pend;  // preemption seen this scan
    logic                   irq;
  } gdh_top_t;

  gdh_top_t           s_r;
  gdh_top_t           s_nxt;
  logic               errstop_s;    // synchronised error-stop level
  logic signed [31:0] follow_vel;   // follower result

  // drive error-stop arrives from outside the clock domain
  gdh_sync gdh_sync_i (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (axis_errstop),
    .dout    (errstop_s)
  );

  // gear follower fed by the ratio registers
  gdh_ratio gdh_ratio_i (
    .pclk       (pclk),
    .presetn    (presetn),
    .master_vel (master_vel),
    .num        (s_r.num),
    .den        (s_r.den),
    .follow_vel (follow_vel)
  );

  // all next state: bus slave, scan sequencer, velocity and interrupts
  always_comb begin
    logic       commit;   // access edge of an apb transfer
    logic       rd_clr;   // read of interrupt status
    logic       rise;
    logic       fall;
    logic [2:0] evt;
    commit = psel && penable && s_r.pready;
    rd_clr = 1'b0;
    rise   = s_r.start && !s_r.start_prev;
    fall   = !s_r.start && s_r.start_prev;
    evt    = '0;
    s_nxt  = s_r;

    // one wait state: answer on the second access cycle
    s_nxt.pready  = psel && penable && !s_r.pready;
    s_nxt.pslverr = 1'b0;
    if (psel && penable && !s_r.pready) begin
      s_nxt.prdata = '0;
      if (paddr == gdh_pkg::OFF_CTRL) begin
        s_nxt.prdata[gdh_pkg::CTRL_START] = s_r.start;
      end else if (paddr == gdh_pkg::OFF_SLAVE) begin
        s_nxt.prdata[15:0] = s_r.slave_sel;
      end else if (paddr == gdh_pkg::OFF_RATIO) begin
        s_nxt.prdata = {s_r.den, s_r.num};
      end else if (paddr == gdh_pkg::OFF_STATUS) begin
        s_nxt.prdata[gdh_pkg::ST_DONE]  = s_r.done;
        s_nxt.prdata[gdh_pkg::ST_BUSY]  = s_r.busy;
        s_nxt.prdata[gdh_pkg::ST_ABORT] = s_r.aborted;
        s_nxt.prdata[gdh_pkg::ST_ERR]   = s_r.error;
        s_nxt.prdata[gdh_pkg::ST_LOCK]  = s_r.lock;
        s_nxt.prdata[gdh_pkg::ST_CONT]  = s_r.cont;
        s_nxt.prdata[gdh_pkg::ST_HALT]  = s_r.halt;
      end else if (paddr == gdh_pkg::OFF_ERRCODE) begin
        s_nxt.prdata = s_r.errcode;
      end else if (paddr == gdh_pkg::OFF_IRQ_STAT) begin
        s_nxt.prdata[2:0] = s_r.irq_stat;
      end else if (paddr == gdh_pkg::OFF_IRQ_MASK) begin
        s_nxt.prdata[2:0] = s_r.mask;
      end else if (paddr == gdh_pkg::OFF_VEL) begin
        s_nxt.prdata = s_r.vel;
      end else begin
        s_nxt.pslverr = 1'b1;   // unmapped: error answer, data zero
      end
    end

    // writes and read side effects take place at the access edge only
    if (commit && pwrite) begin
      if (paddr == gdh_pkg::OFF_CTRL) begin
        s_nxt.start = pwdata[gdh_pkg::CTRL_START];
        // engaging while a cut is running would race the sequencer
        if (pwdata[gdh_pkg::CTRL_ENGAGE] && !s_r.busy) begin
          s_nxt.lock = 1'b1;
          s_nxt.cont = 1'b0;
          s_nxt.halt = 1'b0;
        end
      end else if (paddr == gdh_pkg::OFF_SLAVE) begin
        s_nxt.slave_sel = pwdata[15:0];
      end else if (paddr == gdh_pkg::OFF_RATIO) begin
        s_nxt.num = pwdata[gdh_pkg::RATIO_NUM_LSB +: 16];
        s_nxt.den = pwdata[gdh_pkg::RATIO_DEN_LSB +: 16];
      end else if (paddr == gdh_pkg::OFF_IRQ_MASK) begin
        s_nxt.mask = pwdata[2:0];
      end
    end else if (commit && paddr == gdh_pkg::OFF_IRQ_STAT) begin
      rd_clr = 1'b1;
    end

    // scan period: sequencer flags are evaluated once per tick
    if (s_r.scan_cnt == gdh_pkg::SCAN_LAST) begin
      s_nxt.scan_cnt = '0;
      s_nxt.tick     = 1'b1;
    end else begin
      s_nxt.scan_cnt = s_r.scan_cnt + 7'h01;
      s_nxt.tick     = 1'b0;
    end

    // preemption may come any cycle; held until the next scan
    s_nxt.abort_pend = (s_r.abort_pend && !s_r.tick) ||
                       abort_buffer_mode || axis_stop_command;

    if (s_r.tick) begin
      s_nxt.start_prev = s_r.start;
      if (fall) begin
        s_nxt.done    = 1'b0;
        s_nxt.aborted = 1'b0;
        s_nxt.error   = 1'b0;
        s_nxt.errcode = gdh_pkg::ERR_NONE;
      end else begin
        // a flag set with start already low lasts one scan only
        if (s_r.done && !s_r.start) begin
          s_nxt.done = 1'b0;
        end
        if (s_r.aborted && !s_r.start) begin
          s_nxt.aborted = 1'b0;
        end
      end
      case (s_r.st)
        gdh_pkg::GDH_IDLE: begin
          if (rise) begin
            s_nxt.axis    = s_r.slave_sel;
            s_nxt.done    = 1'b0;
            s_nxt.aborted = 1'b0;
            s_nxt.error   = 1'b0;
            s_nxt.errcode = gdh_pkg::ERR_NONE;
            if (s_r.slave_sel < gdh_pkg::AXIS_MIN ||
                s_r.slave_sel > gdh_pkg::AXIS_MAX) begin
              s_nxt.error   = 1'b1;
              s_nxt.errcode = gdh_pkg::ERR_AXIS;
            end else if (errstop_s) begin
              s_nxt.error   = 1'b1;
              s_nxt.errcode = gdh_pkg::ERR_ESTOP;
              s_nxt.halt    = 1'b1;
              s_nxt.lock    = 1'b0;
              s_nxt.cont    = 1'b0;
            end else if (!s_r.lock) begin
              s_nxt.error   = 1'b1;
              s_nxt.errcode = gdh_pkg::ERR_NOLOCK;
            end else begin
              s_nxt.busy = 1'b1;
              s_nxt.st   = gdh_pkg::GDH_CUT;
            end
          end
        end
        gdh_pkg::GDH_CUT: begin
          s_nxt.busy = 1'b0;
          s_nxt.st   = gdh_pkg::GDH_IDLE;
          if (errstop_s) begin
            s_nxt.error   = 1'b1;
            s_nxt.errcode = gdh_pkg::ERR_ESTOP;
            s_nxt.halt    = 1'b1;
            s_nxt.lock    = 1'b0;
          end else if (s_r.abort_pend) begin
            s_nxt.aborted = 1'b1;
          end else begin
            s_nxt.lock = 1'b0;
            s_nxt.cont = 1'b1;
            s_nxt.done = 1'b1;
          end
        end
        default: begin
          s_nxt.st = gdh_pkg::GDH_IDLE;
        end
      endcase
    end

    // velocity: halted axis stands, coupled axis follows, cut axis holds
    if (s_nxt.halt) begin
      s_nxt.vel = '0;
    end else if (s_nxt.lock) begin
      s_nxt.vel = follow_vel;
    end

    // sticky events; a new event beats a clearing read
    evt[gdh_pkg::IRQ_DONE]  = s_nxt.done && !s_r.done;
    evt[gdh_pkg::IRQ_ABORT] = s_nxt.aborted && !s_r.aborted;
    evt[gdh_pkg::IRQ_ERR]   = s_nxt.error && !s_r.error;
    s_nxt.irq_stat = (rd_clr ? 3'h0 : s_r.irq_stat) | evt;
    s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.mask);
  end

  // state register; flags false, code zero and ratio one over one out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r           <= '0;
      s_r.st        <= gdh_pkg::GDH_IDLE;
      s_r.slave_sel <= gdh_pkg::RST_SLAVE;
      s_r.num       <= gdh_pkg::RST_NUM;
      s_r.den       <= gdh_pkg::RST_DEN;
      s_r.mask      <= gdh_pkg::RST_MASK;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign prdata                  = s_r.prdata;
  assign pready                  = s_r.pready;
  assign pslverr                 = s_r.pslverr;
  assign done                    = s_r.done;
  assign busy                    = s_r.busy;
  assign aborted_flag            = s_r.aborted;
  assign error                   = s_r.error;
  assign error_code_output       = s_r.errcode;
  assign slave_vel               = s_r.vel;
  assign gear_locked_flag        = s_r.lock;
  assign continuous_motion_state = s_r.cont;
  assign halt                    = s_r.halt;
  assign irq                     = s_r.irq;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  busy_start_a: assert property ($rose(s_r.busy) |->
    $past(s_r.tick && s_r.start && !s_r.start_prev))
    else $error("busy rose without a start edge");

  busy_end_a: assert property ($fell(s_r.busy) |->
    (s_r.done || s_r.aborted || s_r.error))
    else $error("busy fell without a result");

  done_cause_a: assert property ($rose(s_r.done) |->
    (s_r.cont && !s_r.lock && $past(s_r.st == gdh_pkg::GDH_CUT)))
    else $error("done without a completed cut");

  done_once_a: assert property ((s_r.tick && s_r.done && !s_r.start) |=>
    !s_r.done)
    else $error("done outlived one scan");

  abort_set_a: assert property ((s_r.tick && s_r.st == gdh_pkg::GDH_CUT
    && s_r.abort_pend && !errstop_s) |=> (s_r.aborted && !s_r.busy && !s_r.done))
    else $error("preemption not reported");

  abort_clear_a: assert property ((s_r.tick && s_r.aborted && !s_r.start) |=>
    !s_r.aborted)
    else $error("aborted outlived one scan");

  axis_range_a: assert property ((s_r.tick && s_r.st == gdh_pkg::GDH_IDLE
    && s_r.start && !s_r.start_prev && s_r.slave_sel > gdh_pkg::AXIS_MAX)
    |=> (s_r.error && s_r.errcode == gdh_pkg::ERR_AXIS && !s_r.busy))
    else $error("bad axis accepted");

  err_clear_a: assert property ((s_r.tick && !s_r.start && s_r.start_prev) |=>
    (!s_r.error && s_r.errcode == gdh_pkg::ERR_NONE))
    else $error("error kept after start fall");

  halt_stop_a: assert property ($rose(s_r.halt) |->
    (s_r.error && s_r.vel == 32'h0000_0000 && !s_r.lock))
    else $error("halt without error or standstill");

  vel_hold_a: assert property ((s_r.cont && $past(s_r.cont) && !s_r.halt) |->
    $stable(s_r.vel))
    else $error("free slave velocity drifted");

  follow_a: assert property ((s_nxt.lock && !s_nxt.halt) |=>
    (s_r.vel == $past(follow_vel)))
    else $error("coupled slave not following");

  done_c: cover property ($rose(s_r.done));
  abort_c: cover property ($rose(s_r.aborted));
  error_c: cover property ($rose(s_r.error) && s_r.halt);
  irq_c: cover property ($rose(s_r.irq));

endmodule

// ===== test/gdh_partner.sv
`timescale 1ns/1ps
// far-side model: motion program feeding master velocity and preempting commands
module gdh_partner (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] vel_set,
  input  wire logic        abort_req,
  input  wire logic        stop_req,
  input  wire logic        estop_req,
  output logic [31:0]      master_vel,
  output logic             abort_buffer_mode,
  output logic             axis_stop_command,
  output logic             axis_errstop
);
  // registered so every change lands just after an edge, as real axis data would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_vel        <= 32'h0;
      abort_buffer_mode <= 1'b0;
      axis_stop_command <= 1'b0;
      axis_errstop      <= 1'b0;
    end else begin
      master_vel        <= vel_set;
      abort_buffer_mode <= abort_req;
      axis_stop_command <= stop_req;
      axis_errstop      <= estop_req;
    end
  end
endmodule

// ===== test/gdh_gear_disengage_block_bench.sv
`timescale 1ns/1ps
// self-checking bench: apb master, outcome queue and two watching monitors
module gdh_gear_disengage_block_bench;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, master_vel, error_code_output, slave_vel, vel_set;
  logic               abort_buffer_mode, axis_stop_command, axis_errstop, irq, halt;
  logic               done, busy, aborted_flag, error, gear_locked_flag, continuous_motion_state;
  logic               abort_req, stop_req, estop_req;
  logic [32:0]        rd_q[$];   // expected {pslverr, prdata} per read
  logic [35:0]        ev_q[$];   // expected {0, done, aborted, error, code}
  logic [2:0]         ev_prev;   // flags at previous negedge
  logic signed [31:0] mv, ve;    // master velocity and expected follower velocity
  logic signed [15:0] num;       // gear numerator under test
  logic [15:0]        sl;        // slave axis number
  integer             seed;
  int                 failures, checks, n, k;

  gdh_gear_disengage_block gdh_gear_disengage_block_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .master_vel(master_vel),
    .abort_buffer_mode(abort_buffer_mode), .axis_stop_command(axis_stop_command),
    .axis_errstop(axis_errstop), .done(done), .busy(busy), .aborted_flag(aborted_flag),
    .error(error), .error_code_output(error_code_output), .slave_vel(slave_vel),
    .gear_locked_flag(gear_locked_flag), .continuous_motion_state(continuous_motion_state),
    .halt(halt), .irq(irq));

  gdh_partner gdh_partner_i (.pclk(pclk), .presetn(presetn), .vel_set(vel_set),
    .abort_req(abort_req), .stop_req(stop_req), .estop_req(estop_req),
    .master_vel(master_vel), .abort_buffer_mode(abort_buffer_mode),
    .axis_stop_command(axis_stop_command), .axis_errstop(axis_errstop));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // a wait that runs out ends the run as a failure
  task timeout(input string nm);
    failures++;
    $display("MISMATCH %s expected event seen timeout", nm);
    final_report();
  endtask

  // one apb transfer; request held until pready is sampled high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) timeout("pready");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  function automatic logic flg(input int i);
    case (i)
      0: return done;
      1: return busy;
      2: return aborted_flag;
      default: return error;
    endcase
  endfunction

  task wait_flag(input int i, input logic v);
    int t;
    t = 0;
    do begin
      @(negedge pclk);
      t++;
    end while (flg(i) !== v && t < 400);
    if (t >= 400) timeout("flag");
  endtask

  // cycles a flag stays high, counted from its first high negedge
  task count_high(input int i, output int c);
    c = 0;
    while (flg(i) === 1'b1 && c < 400) begin
      @(negedge pclk);
      c++;
    end
  endtask

  task engage(input logic [15:0] nm);
    apb(1'b1, gdh_pkg::OFF_RATIO, {16'h0001, nm});
    apb(1'b1, gdh_pkg::OFF_CTRL, 32'h2);
  endtask

  // read monitor: the rising edge that commits a read also takes its data
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("prdata", 36'(rd_q.pop_front()), {3'b0, pslverr, prdata});
    end
  end

  // outcome monitor: any rising result flag takes the oldest note
  always @(negedge pclk) begin
    if (({done, aborted_flag, error} & ~ev_prev) != 3'b0) begin
      chk("outcome", ev_q.pop_front(), {1'b0, done, aborted_flag, error, error_code_output});
    end
    ev_prev = {done, aborted_flag, error};
  end

  initial begin
    seed = 32'h2a556784;
    {psel, penable, pwrite, abort_req, stop_req, estop_req} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    vel_set = 32'h0;
    ev_prev = 3'h0;
    presetn = 1'b0;
    @(negedge pclk);
    chk("reset flags", 36'h0, 36'({done, busy, aborted_flag, error}));
    chk("reset code", 36'h0, 36'(error_code_output));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(gdh_pkg::OFF_RATIO, {1'b0, gdh_pkg::RST_DEN, gdh_pkg::RST_NUM});
    rd(gdh_pkg::OFF_SLAVE, {17'h0, gdh_pkg::RST_SLAVE});
    rd(gdh_pkg::OFF_IRQ_MASK, {30'h0, gdh_pkg::RST_MASK});
    rd(8'h20, 33'h1_0000_0000);
    // start without a coupling is refused with an error
    sl = 16'(($random(seed) & 31) + 1);
    apb(1'b1, gdh_pkg::OFF_SLAVE, {16'h0, sl});
    ev_q.push_back({4'h1, gdh_pkg::ERR_NOLOCK});
    apb(1'b1, gdh_pkg::OFF_CTRL, 32'h1);
    wait_flag(3, 1'b1);
    chk("busy", 36'h0, 36'(busy));
    rd(gdh_pkg::OFF_ERRCODE, {1'b0, gdh_pkg::ERR_NOLOCK});
    apb(1'b1, gdh_pkg::OFF_CTRL, 32'h0);
    wait_flag(3, 1'b0);
    chk("code", 36'h0, 36'(error_code_output));
    // axis numbers just outside the legal range
    for (k = 0; k < 2; k++) begin
      engage(16'h0002);
      apb(1'b1, gdh_pkg::OFF_SLAVE, (k == 0) ? 32'h0 : 32'h21);
      ev_q.push_back({4'h1, gdh_pkg::ERR_AXIS});
      apb(1'b1, gdh_pkg::OFF_CTRL, 32'h1);
      wait_flag(3, 1'b1);
      apb(1'b1, gdh_pkg::OFF_CTRL, 32'h0);
      wait_flag(3, 1'b0);
    end
    // follower at positive and negative ratio
    for (k = 0; k < 2; k++) begin
      num = (k == 0) ? 16'sh0002 : -16'sh0003;
      mv = $random(seed) % 1000;
      ve = mv * num;
      @(posedge pclk);
      vel_set <= mv;
      engage(num);
      repeat (5) @(negedge pclk);
      chk("slave_vel", 36'(ve), 36'(slave_vel));
    end
    chk("irq masked", 36'h0, 36'(irq));
    rd(gdh_pkg::OFF_IRQ_STAT, 33'h4);
    // completed cut with start held high
    apb(1'b1, gdh_pkg::OFF_IRQ_MASK, 32'h1);
    apb(1'b1, gdh_pkg::OFF_SLAVE, {16'h0, 16'(($random(seed) & 31) + 1)});
    ev_q.push_back(36'h4_0000_0000);
    apb(1'b1, gdh_pkg::OFF_CTRL, 32'h1);
    wait_flag(1, 1'b1);
    chk("early done", 36'h0, 36'(done));
    wait_flag(0, 1'b1);
    chk("after cut", 36'h3, 36'({busy, gear_locked_flag, continuous_motion_state, irq}));
    @(posedge pclk);
    vel_set <= mv + 7;
    repeat (5) @(negedge pclk);
    chk("kept vel", 36'(ve), 36'(slave_vel));
    rd(gdh_pkg::OFF_STATUS, 33'((1 << gdh_pkg::ST_DONE) | (1 << gdh_pkg::ST_CONT)));
    rd(gdh_pkg::OFF_VEL, {1'b0, ve});
    rd(gdh_pkg::OFF_IRQ_STAT, 33'h1);
    repeat (2) @(negedge pclk);
    chk("irq cleared", 36'h0, 36'(irq));
    apb(1'b1, gdh_pkg::OFF_CTRL, 32'h1);
    repeat (150) @(negedge pclk);
    chk("held", 36'h2, 36'({done, busy}));
    apb(1'b1, gdh_pkg::OFF_CTRL, 32'h0);
    wait_flag(0, 1'b0);
    // start already low when the cut completes
    engage(16'h0002);
    ev_q.push_back(36'h4_0000_0000);
    apb(1'b1, gdh_pkg::OFF_CTRL, 32'h1);
    wait_flag(1, 1'b1);
    apb(1'b1, gdh_pkg::OFF_CTRL, 32'h0);
    wait_flag(0, 1'b1);
    count_high(0, n);
    chk("done width", 36'd100, 36'(n));
    // preemption by an aborting command, then by a stop
    for (k = 0; k < 2; k++) begin
      engage(16'h0002);
      apb(1'b1, gdh_pkg::OFF_CTRL, 32'h1);
      wait_flag(1, 1'b1);
      apb(1'b1, gdh_pkg::OFF_CTRL, 32'h0);
      ev_q.push_back(36'h2_0000_0000);
      @(posedge pclk);
      abort_req <= (k == 0);
      stop_req  <= (k == 1);
      @(posedge pclk);
      abort_req <= 1'b0;
      stop_req  <= 1'b0;
      wait_flag(2, 1'b1);
      chk("still locked", 36'h1, 36'(gear_locked_flag));
      count_high(2, n);
      chk("abort width", 36'd100, 36'(n));
    end
    // axis in error-stop at start
    engage(16'h0002);
    @(posedge pclk);
    estop_req <= 1'b1;
    repeat (10) @(posedge pclk);
    ev_q.push_back({4'h1, gdh_pkg::ERR_ESTOP});
    apb(1'b1, gdh_pkg::OFF_CTRL, 32'h1);
    wait_flag(3, 1'b1);
    repeat (3) @(negedge pclk);
    chk("halted", {4'h1, 32'h0}, {3'b0, halt, slave_vel});
    @(posedge pclk);
    estop_req <= 1'b0;
    apb(1'b1, gdh_pkg::OFF_CTRL, 32'h0);
    wait_flag(3, 1'b0);
    final_report();
  end
endmodule
